/* eft_top.sv */
// Purpose: AHB-Lite register bank for error flag selection, automatic
//          error counter clearing and I2C address translation.
// Assumes: Error event inputs and the I2C address come from logic on mclk.
// Notes:   Reads take one wait state, writes none.
// Summary of operation
// - Width match bit: 1 means equal, resets 0.
// - Stagger off bit disables staggered outputs.
// - Auto clear zeroes counters 1 us after flag.
// - Auto clear off leaves counters and flag.
// - Source 00 detected, 01 corrected over limit.
// - Source 10/11 flags either counter over limit.
// - Source address A in bits 7:1.
// - Destination address A in bits 7:1.
// - Source address B in bits 7:1.
// - Destination address B in bits 7:1.
// - Two 8-bit counters with writable limits.
`timescale 1ns/100ps
module eft_top
    import eft_pkg::*;
(
    input wire logic mclk,
    input wire logic nrst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic det_err_evt,
    input wire logic corr_err_evt,
    input wire eft_i2c_addr_t i2c_addr_in,
    output eft_i2c_addr_t i2c_addr_out,
    output logic err_flag,
    output logic width_match,
    output logic stagger_off,
    output logic irq
);

    function automatic logic hit(input logic [IDX_W-1:0] a,
                                 input logic [IDX_W-1:0] idx);
        hit = (a == idx);
    endfunction : hit

    logic wr_pend_q;
    logic rd_pend_q;
    logic [IDX_W-1:0] addr_q;
    logic ready_q;
    logic [31:0] rdata_q;
    eft_ctrl_t ctrl_q;
    logic [6:0] src_a_q;
    logic [6:0] dst_a_q;
    logic [6:0] src_b_q;
    logic [6:0] dst_b_q;
    logic [7:0] cnt_q [2];
    logic [7:0] lim_q [2];
    logic [1:0] evt;
    logic [1:0] over;
    logic flag_d;
    logic flag_q;
    logic cnt_clear;
    eft_clr_state_t clr_state_q;
    logic [TMR_W-1:0] tmr_q;
    logic [IRQ_W-1:0] stat_q;
    logic [IRQ_W-1:0] en_q;
    logic [IRQ_W-1:0] stat_set;
    logic irq_q;
    eft_i2c_addr_t i2c_q;
    logic take;
    logic wr_ctrl;
    logic [31:0] rd_mux;

    assign take = hsel & htrans[1] & hready;
    assign evt = {corr_err_evt, det_err_evt};

    // Address phase capture; reads stall one cycle so that the data phase
    // of a preceding write is already committed when read data are formed.
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            addr_q <= '0;
            ready_q <= 1'b1;
        end else begin
            wr_pend_q <= take & hwrite;
            rd_pend_q <= take & ~hwrite;
            if (take) begin
                addr_q <= haddr[IDX_W+1:2];
            end
            if (take & ~hwrite) begin
                ready_q <= 1'b0;
            end else if (rd_pend_q) begin
                ready_q <= 1'b1;
            end
        end
    end

    always_comb begin
        rd_mux = '0;
        unique case (1'b1)
            hit(addr_q, IDX_CTRL): begin
                rd_mux[CTRL_MATCH_BIT] = ctrl_q.width_match;
                rd_mux[CTRL_STAG_BIT] = ctrl_q.stagger_off;
                rd_mux[CTRL_AUTO_BIT] = ctrl_q.auto_clear;
                rd_mux[CTRL_SRC_LSB+:2] = ctrl_q.flag_source;
            end
            hit(addr_q, IDX_SRC_A): rd_mux[ADDR_LSB+:7] = src_a_q;
            hit(addr_q, IDX_DST_A): rd_mux[ADDR_LSB+:7] = dst_a_q;
            hit(addr_q, IDX_SRC_B): rd_mux[ADDR_LSB+:7] = src_b_q;
            hit(addr_q, IDX_DST_B): rd_mux[ADDR_LSB+:7] = dst_b_q;
            hit(addr_q, IDX_DET_LIM): rd_mux[7:0] = lim_q[CNT_DET];
            hit(addr_q, IDX_DET_CNT): rd_mux[7:0] = cnt_q[CNT_DET];
            hit(addr_q, IDX_CORR_LIM): rd_mux[7:0] = lim_q[CNT_CORR];
            hit(addr_q, IDX_CORR_CNT): rd_mux[7:0] = cnt_q[CNT_CORR];
            hit(addr_q, IDX_IRQ_STAT): rd_mux[IRQ_W-1:0] = stat_q;
            hit(addr_q, IDX_IRQ_EN): rd_mux[IRQ_W-1:0] = en_q;
            default: rd_mux = '0;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            rdata_q <= '0;
        end else if (rd_pend_q) begin
            rdata_q <= rd_mux;
        end
    end

    assign wr_ctrl = wr_pend_q & hit(addr_q, IDX_CTRL);

    // Match and stagger off bits drive the pins directly; match is a software-owned
    // statement that both ends use the same input width.
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            ctrl_q <= CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl_q.width_match <= hwdata[CTRL_MATCH_BIT];
            ctrl_q.stagger_off <= hwdata[CTRL_STAG_BIT];
            ctrl_q.auto_clear <= hwdata[CTRL_AUTO_BIT];
            ctrl_q.flag_source <= hwdata[CTRL_SRC_LSB+:2];
        end
    end

    // Translation addresses; bit 0 of each register is reserved.
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            src_a_q <= '0;
            dst_a_q <= '0;
            src_b_q <= '0;
            dst_b_q <= '0;
        end else if (wr_pend_q) begin
            if (hit(addr_q, IDX_SRC_A)) begin
                src_a_q <= hwdata[ADDR_LSB+:7];
            end
            if (hit(addr_q, IDX_DST_A)) begin
                dst_a_q <= hwdata[ADDR_LSB+:7];
            end
            if (hit(addr_q, IDX_SRC_B)) begin
                src_b_q <= hwdata[ADDR_LSB+:7];
            end
            if (hit(addr_q, IDX_DST_B)) begin
                dst_b_q <= hwdata[ADDR_LSB+:7];
            end
        end
    end

    // Error counters saturate at their maximum; the auto clear wins over
    // an event in the same cycle.
    generate
        for (genvar i = 0; i < 2; i++) begin : g_cnt
            localparam logic [IDX_W-1:0] LIM_IDX =
                (i == CNT_DET) ? IDX_DET_LIM : IDX_CORR_LIM;
            always_ff @(posedge mclk) begin
                if (!nrst) begin
                    cnt_q[i] <= '0;
                end else if (cnt_clear) begin
                    cnt_q[i] <= '0;
                end else if (evt[i] && cnt_q[i] != CNT_MAX) begin
                    cnt_q[i] <= cnt_q[i] + 8'h01;
                end
            end
            always_ff @(posedge mclk) begin
                if (!nrst) begin
                    lim_q[i] <= '0;
                end else if (wr_pend_q && hit(addr_q, LIM_IDX)) begin
                    lim_q[i] <= hwdata[7:0];
                end
            end
            assign over[i] = cnt_q[i] > lim_q[i];
        end
    endgenerate

    always_comb begin
        unique case (ctrl_q.flag_source)
            SRC_DET: flag_d = over[CNT_DET];
            SRC_CORR: flag_d = over[CNT_CORR];
            default: flag_d = over[CNT_DET] | over[CNT_CORR];
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            flag_q <= 1'b0;
        end else begin
            flag_q <= flag_d;
        end
    end

    // Auto clear timer starts on the rising edge of the flag; with the
    // feature off the counters and flag are left alone.
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            clr_state_q <= CLR_IDLE;
            tmr_q <= '0;
        end else begin
            unique case (clr_state_q)
                CLR_IDLE: begin
                    if (flag_d & ~flag_q & ctrl_q.auto_clear) begin
                        clr_state_q <= CLR_WAIT;
                        tmr_q <= TMR_W'(AUTO_CLR_CYC - 1);
                    end
                end
                CLR_WAIT: begin
                    if (!ctrl_q.auto_clear) begin
                        clr_state_q <= CLR_IDLE;
                    end else if (tmr_q == '0) begin
                        clr_state_q <= CLR_IDLE;
                    end else begin
                        tmr_q <= tmr_q - 1'b1;
                    end
                end
            endcase
        end
    end

    assign cnt_clear = (clr_state_q == CLR_WAIT) && ctrl_q.auto_clear &&
                       (tmr_q == '0);

    // Sticky interrupt status; a new event wins over a clear write.
    always_comb begin
        stat_set = '0;
        stat_set[IRQ_FLAG_BIT] = flag_d & ~flag_q;
        stat_set[IRQ_CLR_BIT] = cnt_clear;
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            stat_q <= '0;
        end else if (wr_pend_q && hit(addr_q, IDX_IRQ_CLR)) begin
            stat_q <= (stat_q & ~hwdata[IRQ_W-1:0]) | stat_set;
        end else begin
            stat_q <= stat_q | stat_set;
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            en_q <= '0;
        end else if (wr_pend_q && hit(addr_q, IDX_IRQ_EN)) begin
            en_q <= hwdata[IRQ_W-1:0];
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(stat_q & en_q);
        end
    end

    // Address translation of forwarded I2C transactions.
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            i2c_q <= '0;
        end else begin
            i2c_q.valid <= i2c_addr_in.valid;
            if (i2c_addr_in.addr == src_a_q) begin
                i2c_q.addr <= dst_a_q;
            end else if (i2c_addr_in.addr == src_b_q) begin
                i2c_q.addr <= dst_b_q;
            end else begin
                i2c_q.addr <= i2c_addr_in.addr;
            end
        end
    end

    assign hreadyout = ready_q;
    assign hresp = 1'b0;
    assign hrdata = rdata_q;
    assign err_flag = flag_q;
    assign width_match = ctrl_q.width_match;
    assign stagger_off = ctrl_q.stagger_off;
    assign irq = irq_q;
    assign i2c_addr_out = i2c_q;

endmodule : eft_top

/* eft_pkg.sv */
// Purpose: Shared constants and types of the error flag and address
//          translation configuration block.
// Assumes: Register index times four is the AHB byte address.
// Notes:   Indexes below 0x20 follow the device map.
package eft_pkg;

    localparam int unsigned IDX_W = 6;
    localparam logic [IDX_W-1:0] IDX_CTRL = 6'h08;
    localparam logic [IDX_W-1:0] IDX_SRC_A = 6'h09;
    localparam logic [IDX_W-1:0] IDX_DST_A = 6'h0A;
    localparam logic [IDX_W-1:0] IDX_SRC_B = 6'h0B;
    localparam logic [IDX_W-1:0] IDX_DST_B = 6'h0C;
    localparam logic [IDX_W-1:0] IDX_DET_LIM = 6'h0F;
    localparam logic [IDX_W-1:0] IDX_DET_CNT = 6'h10;
    localparam logic [IDX_W-1:0] IDX_CORR_LIM = 6'h11;
    localparam logic [IDX_W-1:0] IDX_CORR_CNT = 6'h12;
    localparam logic [IDX_W-1:0] IDX_IRQ_STAT = 6'h20;
    localparam logic [IDX_W-1:0] IDX_IRQ_CLR = 6'h21;
    localparam logic [IDX_W-1:0] IDX_IRQ_EN = 6'h22;

    // Control and address register field positions.
    localparam int unsigned CTRL_MATCH_BIT = 4;
    localparam int unsigned CTRL_STAG_BIT = 3;
    localparam int unsigned CTRL_AUTO_BIT = 2;
    localparam int unsigned CTRL_SRC_LSB = 0;
    localparam int unsigned ADDR_LSB = 1;

    // Interrupt status bit positions.
    localparam int unsigned IRQ_FLAG_BIT = 0;
    localparam int unsigned IRQ_CLR_BIT = 1;
    localparam int unsigned IRQ_W = 2;

    localparam int unsigned CNT_DET = 0;
    localparam int unsigned CNT_CORR = 1;
    localparam logic [7:0] CNT_MAX = 8'hFF;

    localparam logic [1:0] SRC_DET = 2'h0;
    localparam logic [1:0] SRC_CORR = 2'h1;

    // Auto clear delay: 1 us at 200 MHz.
    localparam int unsigned CLK_MHZ = 200;
    localparam int unsigned AUTO_CLR_NS = 1000;
    localparam int unsigned AUTO_CLR_CYC = AUTO_CLR_NS * CLK_MHZ / 1000;
    localparam int unsigned TMR_W = 8;

    typedef struct packed {
        logic width_match;
        logic stagger_off;
        logic auto_clear;
        logic [1:0] flag_source;
    } eft_ctrl_t;

    localparam eft_ctrl_t CTRL_RESET = '{1'b0, 1'b0, 1'b0, 2'h0};

    typedef struct packed {
        logic valid;
        logic [6:0] addr;
    } eft_i2c_addr_t;

    typedef enum logic [0:0] {
        CLR_IDLE = 1'b0,
        CLR_WAIT = 1'b1
    } eft_clr_state_t;

endpackage : eft_pkg

/* eft_host.sv */
// Purpose: AHB-Lite master standing in for the host processor.
// Assumes: One slave whose hreadyout is the bus hready.
// Notes: Signals change by non-blocking assignment after mclk rises.
`timescale 1ns/100ps
module eft_host (
    input wire logic mclk,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata
);
    initial begin
        {hsel, haddr, htrans, hwrite, hwdata} = '0;
        hsize = 3'h2;
    end

    // Hready is read at the falling edge so the rising edge sees it settled.
    task automatic xfer(input logic w, input logic [5:0] i,
        input logic [31:0] d, output logic [31:0] q);
        logic r;
        @(posedge mclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, i, 2'h0};
        do begin
            @(negedge mclk);
            r = hready;
            @(posedge mclk);
        end while (r !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do begin
            @(negedge mclk);
            r = hready;
            q = hrdata;
            @(posedge mclk);
        end while (r !== 1'b1);
    endtask : xfer
endmodule : eft_host

/* eft_props.sv */
// Purpose: Concurrent checks on the ports of eft_top.
// Assumes: Single clock mclk, synchronous active low nrst.
// Notes: Bound to every eft_top instance.
`timescale 1ns/100ps
module eft_chk
    import eft_pkg::*;
(
    input wire logic mclk,
    input wire logic nrst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    input wire logic det_err_evt,
    input wire logic corr_err_evt,
    input wire eft_i2c_addr_t i2c_addr_in,
    input wire eft_i2c_addr_t i2c_addr_out,
    input wire logic err_flag,
    input wire logic width_match,
    input wire logic stagger_off
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    wire take = hsel & htrans[1] & hready;
    wire ctl_wr = take & hwrite & (haddr[7:2] == IDX_CTRL);
    wire cause = det_err_evt | corr_err_evt | (take & hwrite);

    a_resp_okay: assert property (hresp == 1'b0)
        else $error("hresp not okay");
    a_read_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
    a_write_nowait: assert property (take && hwrite |=> hreadyout)
        else $error("write stalled");
    a_match_by_write: assert property (
        $changed(width_match) |-> $past(ctl_wr, 2))
        else $error("width match changed without write");
    a_stag_by_write: assert property (
        $changed(stagger_off) |-> $past(ctl_wr, 2))
        else $error("stagger off changed without write");
    a_valid_passes: assert property (
        $past(nrst) |-> i2c_addr_out.valid == $past(i2c_addr_in.valid))
        else $error("i2c valid not passed on");
    a_rdata_on_read: assert property (
        $changed(hrdata) |-> $past(take && !hwrite, 2))
        else $error("hrdata changed without read");
    a_flag_has_cause: assert property (
        $rose(err_flag) |-> $past(cause, 2) || $past(cause, 3))
        else $error("error flag rose without cause");
endmodule : eft_chk

bind eft_top eft_chk eft_chk_i (.mclk(mclk), .nrst(nrst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .det_err_evt(det_err_evt), .corr_err_evt(corr_err_evt),
    .i2c_addr_in(i2c_addr_in), .i2c_addr_out(i2c_addr_out),
    .err_flag(err_flag), .width_match(width_match),
    .stagger_off(stagger_off));

/* testbench.sv */
// Purpose: Self-checking bench for the eft_top register bank.
// Assumes: Auto clear delay of 200 cycles at 200 MHz.
// Notes: Host model drives the bus; the bench drives events and i2c.
`timescale 1ns/100ps
module testbench
    import eft_pkg::*;
;
    logic mclk = 1'b0;
    logic nrst, hsel, hwrite, hready, hresp, err_flag, irq;
    logic det_err_evt, corr_err_evt, width_match, stagger_off;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    eft_i2c_addr_t i2c_addr_in, i2c_addr_out;
    int errors = 0;
    int n_tests = 0;
    int cyc = 0;
    always #2.5 mclk = ~mclk;

    eft_host eft_host_i (.mclk(mclk), .hready(hready), .hrdata(hrdata),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata));
    eft_top eft_top_i (.mclk(mclk), .nrst(nrst), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hreadyout(hready),
        .hresp(hresp), .hrdata(hrdata), .det_err_evt(det_err_evt),
        .corr_err_evt(corr_err_evt), .i2c_addr_in(i2c_addr_in),
        .i2c_addr_out(i2c_addr_out), .err_flag(err_flag),
        .width_match(width_match), .stagger_off(stagger_off), .irq(irq));

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_of_test

    task automatic chk(input string nm, input logic [31:0] got, exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s exp %h got %h", nm, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [5:0] i, input logic [31:0] d);
        logic [31:0] q;
        eft_host_i.xfer(1'b1, i, d, q);
    endtask : wr

    task automatic rd(input logic [5:0] i, input logic [31:0] e);
        logic [31:0] q;
        eft_host_i.xfer(1'b0, i, 32'h0, q);
        chk($sformatf("reg %h", i), q, e);
    endtask : rd

    // Checks a level output once the last write has settled; the pin is
    // read after the wait, not when the task is called.
    task automatic pin(input string nm, input logic exp);
        logic got;
        repeat (2) @(negedge mclk);
        case (nm)
            "width_match": got = width_match;
            "stagger_off": got = stagger_off;
            "flag": got = err_flag;
            default: got = irq;
        endcase
        chk(nm, {31'h0, got}, {31'h0, exp});
    endtask : pin

    task automatic pulse(input logic d, input logic c);
        repeat (3) begin
            @(posedge mclk);
            det_err_evt <= d;
            corr_err_evt <= c;
            @(posedge mclk);
            det_err_evt <= 1'b0;
            corr_err_evt <= 1'b0;
        end
    endtask : pulse

    task automatic xl(input logic [6:0] a, input logic [6:0] e);
        @(posedge mclk);
        i2c_addr_in <= {1'b1, a};
        @(posedge mclk);
        @(negedge mclk);
        chk("i2c", {24'h0, i2c_addr_out}, {25'h1, e});
    endtask : xl

    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            end_of_test();
        end
    end

    initial begin
        {nrst, det_err_evt, corr_err_evt} = '0;
        i2c_addr_in = '0;
        repeat (16) @(posedge mclk);
        nrst <= 1'b1;
        for (int i = 8; i <= 12; i++) begin
            rd(6'(i), 32'h0);
        end
        rd(IDX_DET_LIM, 32'h0);
        rd(IDX_CORR_LIM, 32'h0);
        rd(6'h3F, 32'h0);
        for (int i = 9; i <= 12; i++) begin
            wr(6'(i), 32'hFF);
            rd(6'(i), 32'hFE);
        end
        $display("register test done");
        wr(IDX_SRC_A, 32'h20);
        wr(IDX_DST_A, 32'h40);
        wr(IDX_SRC_B, 32'h22);
        wr(IDX_DST_B, 32'h44);
        xl(7'h10, 7'h20);
        xl(7'h11, 7'h22);
        xl(7'h33, 7'h33);
        $display("translation test done");
        wr(IDX_CTRL, 32'h18);
        pin("width_match", 1'b1);
        pin("stagger_off", 1'b1);
        rd(IDX_CTRL, 32'h18);
        $display("control test done");
        wr(IDX_DET_LIM, 32'h2);
        wr(IDX_CORR_LIM, 32'h2);
        rd(IDX_CORR_LIM, 32'h2);
        pulse(1'b1, 1'b0);
        pulse(1'b0, 1'b1);
        wr(IDX_DET_CNT, 32'hFF);
        rd(IDX_DET_CNT, 32'h3);
        rd(IDX_CORR_CNT, 32'h3);
        for (int p = 0; p < 2; p++) begin
            wr(IDX_DET_LIM, p ? 32'h2 : 32'h10);
            wr(IDX_CORR_LIM, p ? 32'h10 : 32'h2);
            for (int s = 0; s < 4; s++) begin
                wr(IDX_CTRL, 32'(s));
                pin("flag", p ? s != 1 : s != 0);
            end
        end
        wr(IDX_CTRL, 32'h0);
        repeat (300) @(posedge mclk);
        rd(IDX_DET_CNT, 32'h3);
        pin("flag", 1'b1);
        wr(IDX_CTRL, 32'h5);
        wr(IDX_CTRL, 32'h4);
        repeat (150) @(posedge mclk);
        rd(IDX_DET_CNT, 32'h3);
        repeat (100) @(posedge mclk);
        rd(IDX_DET_CNT, 32'h0);
        rd(IDX_CORR_CNT, 32'h0);
        pin("flag", 1'b0);
        $display("error flag test done");
        rd(IDX_IRQ_STAT, 32'h3);
        pin("irq", 1'b0);
        wr(IDX_IRQ_EN, 32'h1);
        pin("irq", 1'b1);
        wr(IDX_IRQ_CLR, 32'h3);
        pin("irq", 1'b0);
        rd(IDX_IRQ_STAT, 32'h0);
        rd(IDX_IRQ_CLR, 32'h0);
        $display("interrupt test done");
        end_of_test();
    end
endmodule : testbench
